// ===== common/vr_regs_pkg.sv
package vr_regs_pkg;

    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [7:0] CMD_CONFIGURATION_REVISION = 8'h47;
    localparam logic [7:0] CMD_OC_WARN_THRESHOLD      = 8'h4A;
    localparam logic [7:0] CMD_PHASE_OFFSETS_TWO_FOUR = 8'h4C;
    localparam logic [7:0] CMD_PHASE_OFFSETS_FIVE_SIX = 8'h4D;

    // ****************************************************************
    // field layout and masks
    // ****************************************************************
    localparam int          APP_REV_MSB     = 15;
    localparam int          APP_REV_LSB     = 12;
    localparam int          SIL_REV_MSB     = 11;
    localparam int          SIL_REV_LSB     = 8;
    localparam int          FW_REV_MSB      = 7;
    localparam int          FW_REV_LSB      = 0;
    localparam int          OFFSET_W        = 5;
    localparam int          THRESHOLD_W     = 10;
    localparam int          IOUT_W          = 12;
    localparam logic [15:0] THRESHOLD_MASK  = 16'h03FF;
    localparam logic [15:0] OFFSETS1_MASK   = 16'h7FFF;
    localparam logic [15:0] OFFSETS2_MASK   = 16'h03FF;
    localparam logic [15:0] ZERO_WORD       = 16'h0000;
    localparam int          PHASE_TWO_LSB   = 0;
    localparam int          PHASE_THREE_LSB = 5;
    localparam int          PHASE_FOUR_LSB  = 10;
    localparam int          PHASE_FIVE_LSB  = 0;
    localparam int          PHASE_SIX_LSB   = 5;

    // ****************************************************************
    // revision codes (values arbitrary)
    // ****************************************************************
    localparam logic [3:0]  APP_REV_ENGINEERING = 4'hA;
    localparam logic [3:0]  APP_REV_PRODUCTION  = 4'h5;
    localparam logic [3:0]  SILICON_REV_INDEX   = 4'h1;
    localparam logic [7:0]  FIRMWARE_REV_RESET  = 8'h01;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [15:0] OFFSETS1_RESET  = 16'h0000;
    localparam logic [15:0] OFFSETS2_RESET  = 16'h0000;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  code;
        logic        wr_en;
        logic        rd_en;
        logic [15:0] wr_data;
    } reg_cmd_t;

    typedef struct packed {
        logic signed [OFFSET_W-1:0] phase_six;
        logic signed [OFFSET_W-1:0] phase_five;
        logic signed [OFFSET_W-1:0] phase_four;
        logic signed [OFFSET_W-1:0] phase_three;
        logic signed [OFFSET_W-1:0] phase_two;
    } phase_offsets_t;

    typedef struct packed {
        logic              valid;
        logic [IOUT_W-1:0] amps;
    } iout_sample_t;

endpackage

// ===== verilog/revision_ocwarn_phase_offset_regs.sv
`timescale 1ns/1ps
module revision_ocwarn_phase_offset_regs
#(
    parameter logic [3:0] APP_REV_RESET = vr_regs_pkg::APP_REV_ENGINEERING
)
(
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire vr_regs_pkg::reg_cmd_t      cmd,
    output      logic [15:0]                rd_data,
    input  wire vr_regs_pkg::iout_sample_t  iout,
    input  wire logic                       total_current_lsb_select,
    output      logic                       oc_warn,
    output      logic                       oc_warn_set,
    output      vr_regs_pkg::phase_offsets_t balance_offsets
);
    import vr_regs_pkg::*;

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [15:0] configuration_revision;
    logic [15:0] output_overcurrent_warning_threshold;
    logic [15:0] phase_offsets_two_to_four;
    logic [15:0] phase_offsets_five_six;
    logic [15:0] next_configuration_revision;
    logic [15:0] next_output_overcurrent_warning_threshold;
    logic [15:0] next_phase_offsets_two_to_four;
    logic [15:0] next_phase_offsets_five_six;
    logic [15:0] next_rd_data;
    logic        next_oc_warn;
    logic        next_oc_warn_set;
    logic [IOUT_W-1:0] limit_amps;
    logic [15:0] wr_word;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] write_masked(input logic [15:0] d,
                                                 input logic [15:0] m);
        write_masked = d & m;
    endfunction

    // writable bits of each mapped word; unmapped words have none
    function automatic logic [15:0] code_mask(input logic [7:0] code);
        case (code)
            CMD_CONFIGURATION_REVISION:
                code_mask = ~ZERO_WORD;
            CMD_OC_WARN_THRESHOLD:
                code_mask = THRESHOLD_MASK;
            CMD_PHASE_OFFSETS_TWO_FOUR:
                code_mask = OFFSETS1_MASK;
            CMD_PHASE_OFFSETS_FIVE_SIX:
                code_mask = OFFSETS2_MASK;
            default:
                code_mask = ZERO_WORD;
        endcase
    endfunction

    function automatic logic signed [OFFSET_W-1:0] field5(
        input logic [15:0] r, input int lsb);
        field5 = OFFSET_W'(r >> lsb);
    endfunction

    // warning limit in amperes; coarse mode doubles the threshold
    function automatic logic [IOUT_W-1:0] limit_of(
        input logic [15:0] thr, input logic coarse);
        limit_of = IOUT_W'(thr[THRESHOLD_W-1:0]);
        if (coarse)
            limit_of = IOUT_W'({thr[THRESHOLD_W-1:0], 1'b0});
    endfunction

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_comb
    begin
        wr_word = write_masked(cmd.wr_data, code_mask(cmd.code));
        next_configuration_revision = configuration_revision;
        next_output_overcurrent_warning_threshold =
            output_overcurrent_warning_threshold;
        next_phase_offsets_two_to_four = phase_offsets_two_to_four;
        next_phase_offsets_five_six    = phase_offsets_five_six;
        if (cmd.wr_en)
        begin
            case (cmd.code)
                CMD_CONFIGURATION_REVISION:
                    next_configuration_revision = wr_word;
                CMD_OC_WARN_THRESHOLD:
                    next_output_overcurrent_warning_threshold = wr_word;
                CMD_PHASE_OFFSETS_TWO_FOUR:
                    next_phase_offsets_two_to_four = wr_word;
                CMD_PHASE_OFFSETS_FIVE_SIX:
                    next_phase_offsets_five_six = wr_word;
                default:
                    next_configuration_revision = configuration_revision;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            configuration_revision <= {APP_REV_RESET, SILICON_REV_INDEX,
                                       FIRMWARE_REV_RESET};
            output_overcurrent_warning_threshold <= THRESHOLD_RESET;
            phase_offsets_two_to_four <= OFFSETS1_RESET;
            phase_offsets_five_six    <= OFFSETS2_RESET;
        end
        else
        begin
            configuration_revision <= next_configuration_revision;
            output_overcurrent_warning_threshold <=
                next_output_overcurrent_warning_threshold;
            phase_offsets_two_to_four <= next_phase_offsets_two_to_four;
            phase_offsets_five_six    <= next_phase_offsets_five_six;
        end
    end

    // ****************************************************************
    // read back
    // ****************************************************************
    // a read in the cycle of a write returns the old word
    always_comb
    begin
        next_rd_data = rd_data;
        if (cmd.rd_en)
        begin
            case (cmd.code)
                CMD_CONFIGURATION_REVISION:
                    next_rd_data = configuration_revision;
                CMD_OC_WARN_THRESHOLD:
                    next_rd_data = output_overcurrent_warning_threshold;
                CMD_PHASE_OFFSETS_TWO_FOUR:
                    next_rd_data = phase_offsets_two_to_four;
                CMD_PHASE_OFFSETS_FIVE_SIX:
                    next_rd_data = phase_offsets_five_six;
                default:
                    next_rd_data = ZERO_WORD;
            endcase
            // reserved bits forced low on the way out as well
            next_rd_data = write_masked(next_rd_data,
                                        code_mask(cmd.code));
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rd_data <= ZERO_WORD;
        else
            rd_data <= next_rd_data;
    end

    // ****************************************************************
    // over-current warning compare
    // ****************************************************************
    always_comb
    begin
        limit_amps = limit_of(output_overcurrent_warning_threshold,
                              total_current_lsb_select);
        next_oc_warn     = oc_warn;
        next_oc_warn_set = 1'b0;
        if (iout.valid)
        begin
            next_oc_warn     = iout.amps > limit_amps;
            next_oc_warn_set = iout.amps > limit_amps;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oc_warn     <= 1'b0;
            oc_warn_set <= 1'b0;
        end
        else
        begin
            oc_warn     <= next_oc_warn;
            oc_warn_set <= next_oc_warn_set;
        end
    end

    // ****************************************************************
    // balance loop offsets
    // ****************************************************************
    always_comb
    begin
        balance_offsets.phase_four  =
            field5(phase_offsets_two_to_four, PHASE_FOUR_LSB);
        balance_offsets.phase_three =
            field5(phase_offsets_two_to_four, PHASE_THREE_LSB);
        balance_offsets.phase_two   =
            field5(phase_offsets_two_to_four, PHASE_TWO_LSB);
        balance_offsets.phase_six   =
            field5(phase_offsets_five_six, PHASE_SIX_LSB);
        balance_offsets.phase_five  =
            field5(phase_offsets_five_six, PHASE_FIVE_LSB);
    end

endmodule

// ===== verif/vr_regs_assertions.sv
`timescale 1ns/1ps
module vr_regs_checker
    import vr_regs_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        resetn,
    input wire vr_regs_pkg::reg_cmd_t       cmd,
    input wire logic [15:0]                 rd_data,
    input wire vr_regs_pkg::iout_sample_t   iout,
    input wire logic                        total_current_lsb_select,
    input wire logic                        oc_warn,
    input wire logic                        oc_warn_set,
    input wire vr_regs_pkg::phase_offsets_t balance_offsets
);
    logic [9:0]  thr;
    logic [10:0] limit;
    // mirror of the threshold, doubled in the coarse mode
    assign limit = total_current_lsb_select ? {thr, 1'b0} : {1'b0, thr};
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            thr <= 10'h000;
        else if (cmd.wr_en && cmd.code == CMD_OC_WARN_THRESHOLD)
            thr <= cmd.wr_data[9:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    warn_compare_a: assert property (
        iout.valid |=> oc_warn == ($past(iout.amps) > $past(limit)))
        else $error("warning level differs from compare");
    set_pulse_a: assert property (
        iout.valid |=> oc_warn_set == oc_warn) else $error("set pulse wrong");
    set_idle_a: assert property (
        !iout.valid |=> !oc_warn_set) else $error("set pulse without sample");
    warn_hold_a: assert property (
        !iout.valid |=> $stable(oc_warn)) else $error("warning moved");
    offs_low_a: assert property (
        cmd.wr_en && cmd.code == CMD_PHASE_OFFSETS_TWO_FOUR
        |=> balance_offsets[14:0] == $past(cmd.wr_data[14:0]))
        else $error("phases two to four not applied");
    offs_high_a: assert property (
        cmd.wr_en && cmd.code == CMD_PHASE_OFFSETS_FIVE_SIX
        |=> balance_offsets[24:15] == $past(cmd.wr_data[9:0]))
        else $error("phases five and six not applied");
    rd_low_a: assert property (
        cmd.rd_en && cmd.code == CMD_PHASE_OFFSETS_TWO_FOUR
        |=> rd_data == {1'b0, $past(balance_offsets[14:0])})
        else $error("first offset readback wrong");
    rd_high_a: assert property (
        cmd.rd_en && cmd.code == CMD_PHASE_OFFSETS_FIVE_SIX
        |=> rd_data == {6'h00, $past(balance_offsets[24:15])})
        else $error("second offset readback wrong");
    thr_reserved_a: assert property (
        cmd.rd_en && cmd.code == CMD_OC_WARN_THRESHOLD
        |=> rd_data[15:10] == 6'h00) else $error("reserved bits set");
    cover property (iout.valid ##1 oc_warn_set);
    cover property (iout.valid && total_current_lsb_select);
    cover property (cmd.wr_en && cmd.code == CMD_PHASE_OFFSETS_FIVE_SIX);
endmodule
bind revision_ocwarn_phase_offset_regs vr_regs_checker checker_i (
    .clk(clk), .resetn(resetn), .cmd(cmd), .rd_data(rd_data), .iout(iout),
    .total_current_lsb_select(total_current_lsb_select), .oc_warn(oc_warn),
    .oc_warn_set(oc_warn_set), .balance_offsets(balance_offsets));

// ===== verif/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model
    import vr_regs_pkg::*;
(
    input  wire logic            clk,
    input  wire logic [15:0]     rd_data,
    output vr_regs_pkg::reg_cmd_t cmd
);
    initial cmd = '0;
    function automatic logic [4:0] offset_code(int i_a, int k, int r);
        return 5'(512 * i_a * k * r / 1600);
    endfunction
    // one word access, data taken once the answer has landed
    task automatic access(input logic [7:0] c, input logic wr,
                          input logic [15:0] d, output logic [15:0] q);
        @(negedge clk);
        cmd = '{c, wr, !wr, d};
        @(negedge clk);
        cmd = '0;
        @(negedge clk);
        q = rd_data;
    endtask
endmodule

// ===== verif/revision_ocwarn_phase_offset_regs_test.sv
`timescale 1ns/1ps
`define CHK(a, b) n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end
module revision_ocwarn_phase_offset_regs_test;
    import vr_regs_pkg::*;
    logic           clk = 0, resetn = 0, sel = 0;
    logic           oc_warn, oc_warn_set;
    logic [15:0]    rd_data, q;
    logic [4:0]     p_pos, p_neg;
    reg_cmd_t       cmd;
    iout_sample_t   iout = '0;
    phase_offsets_t offs;
    int             err_total = 0, n_compared = 0;
    always #4 clk = ~clk;
    revision_ocwarn_phase_offset_regs revision_ocwarn_phase_offset_regs_i (
        .clk(clk), .resetn(resetn), .cmd(cmd), .rd_data(rd_data),
        .iout(iout), .total_current_lsb_select(sel), .oc_warn(oc_warn),
        .oc_warn_set(oc_warn_set), .balance_offsets(offs));
    pmbus_host_model pmbus_host_model_i (
        .clk(clk), .rd_data(rd_data), .cmd(cmd));
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        pmbus_host_model_i.access(c, 1'b1, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        pmbus_host_model_i.access(c, 1'b0, 16'h0000, q);
        `CHK(q, e)
    endtask
    task automatic meas(input logic s, input logic [11:0] a, input logic e);
        @(negedge clk);
        sel = s;
        iout = '{1'b1, a};
        @(negedge clk);
        iout.valid = 1'b0;
        `CHK(oc_warn, e)
        `CHK(oc_warn_set, e)
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        rd_chk(CMD_CONFIGURATION_REVISION, {APP_REV_ENGINEERING,
            SILICON_REV_INDEX, FIRMWARE_REV_RESET});
        wr(CMD_CONFIGURATION_REVISION, 16'hFFFF);
        rd_chk(CMD_CONFIGURATION_REVISION, 16'hFFFF);
        $display("test revision done");
        wr(CMD_OC_WARN_THRESHOLD, 16'hFFFF);
        rd_chk(CMD_OC_WARN_THRESHOLD, 16'h03FF);
        wr(CMD_PHASE_OFFSETS_TWO_FOUR, 16'hFFFF);
        rd_chk(CMD_PHASE_OFFSETS_TWO_FOUR, 16'h7FFF);
        wr(CMD_PHASE_OFFSETS_FIVE_SIX, 16'hFFFF);
        rd_chk(CMD_PHASE_OFFSETS_FIVE_SIX, 16'h03FF);
        wr(8'h48, 16'hFFFF);
        rd_chk(8'h48, 16'h0000);
        $display("test reserved done");
        p_pos = pmbus_host_model_i.offset_code(1, 5, 5);
        p_neg = pmbus_host_model_i.offset_code(-1, 5, 5);
        wr(CMD_PHASE_OFFSETS_TWO_FOUR, {1'b0, p_pos, p_neg, 5'h01});
        `CHK(offs.phase_four, 5'h08)
        `CHK(offs.phase_three, 5'h18)
        `CHK(offs.phase_two, 5'h01)
        `CHK($signed(offs.phase_three) < 0, 1'b1)
        wr(CMD_PHASE_OFFSETS_FIVE_SIX, {6'h00, p_neg, p_pos});
        `CHK(offs.phase_six, 5'h18)
        `CHK(offs.phase_five, 5'h08)
        rd_chk(CMD_PHASE_OFFSETS_FIVE_SIX, 16'h0308);
        $display("test offsets done");
        wr(CMD_OC_WARN_THRESHOLD, 16'h0064);
        meas(1'b1, 12'h0C9, 1'b1);
        meas(1'b1, 12'h0C8, 1'b0);
        meas(1'b0, 12'h065, 1'b1);
        meas(1'b0, 12'h064, 1'b0);
        $display("test warning done");
        give_verdict();
    end
endmodule
